/* File: logic/cie_core_int.sv */
`timescale 1ns/1ps
// Core interrupt entry and return with the system interrupt controller.
module cie_core_int (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [7:0]  irq_pin_n,
    input  wire logic [3:0]  sys_src_req,
    input  wire logic [31:0] sys_src_level,
    input  wire logic [31:0] pbus_level_req,
    input  wire logic        mask_wr,
    input  wire logic [15:0] mask_wdata,
    input  wire logic        spr_wr,
    input  wire logic [9:0]  spr_addr,
    input  wire logic [31:0] spr_wdata,
    input  wire logic        msr_wr,
    input  wire logic [31:0] msr_wdata,
    input  wire logic        dec_req,
    input  wire logic        instr_busy,
    input  wire logic [31:0] next_pc,
    input  wire logic        rfi_exec,
    output logic      [15:0] pending_q,
    output logic      [15:0] mask_q,
    output logic      [7:0]  int_code_q,
    output logic             core_req_q,
    output logic      [31:0] machine_state_reg_q,
    output logic      [31:0] saved_pc_q,
    output logic      [31:0] saved_state_q,
    output logic             issue_hold_q,
    output logic             redirect_q,
    output logic      [31:0] redirect_pc_q
);

    // Pins come from outside the clock domain, so they are synchronised.
    logic [7:0] pin_sync;

    cie_sync2 #(
        .W (cie_pkg::NUM_PINS)
    ) u_pin_sync (
        .clk      (clk),
        .nrst     (nrst),
        .async_in (irq_pin_n),
        .sync_out (pin_sync)
    );

    // A system source field uses one-hot format with level 0 at the top.
    function automatic logic field_hits(input logic [7:0] f, input int lvl);
        return f[7 - lvl];
    endfunction

    // Level lines gathered from system sources and the peripheral bus.
    logic [7:0] sys_lvl;
    logic [7:0] pbus_lvl;
    logic [7:0] level_line;
    logic       pbus_merged;

    // Any peripheral request at level seven or above lands on level 7.
    assign pbus_merged = |pbus_level_req[cie_pkg::NUM_PBUS_LVL-1:
                                         cie_pkg::MERGE_LEVEL];

    genvar gl;
    generate
        for (gl = 0; gl < cie_pkg::NUM_LEVELS; gl++)
        begin : g_lvl
            logic [3:0] hit;
            genvar gs;
            for (gs = 0; gs < cie_pkg::NUM_SYS_SRC; gs++)
            begin : g_src
                assign hit[gs] = sys_src_req[gs] &
                    field_hits(sys_src_level[gs*8 +: 8], gl);
            end
            assign sys_lvl[gl] = |hit;
            if (gl == cie_pkg::MERGE_LEVEL)
            begin : g_merge
                assign pbus_lvl[gl] = pbus_merged;
            end
            else
            begin : g_direct
                assign pbus_lvl[gl] = pbus_level_req[gl];
            end
        end
    endgenerate

    assign level_line = sys_lvl | pbus_lvl;

    // Pins take even slots and levels odd slots, so codes interleave.
    logic [15:0] pend_d;

    generate
        for (gl = 0; gl < cie_pkg::NUM_PINS; gl++)
        begin : g_pend
            assign pend_d[2*gl]     = ~pin_sync[gl];
            assign pend_d[2*gl + 1] = level_line[gl];
        end
    endgenerate

    // Pending follows the live inputs; software reads it at any time.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pending_q <= cie_pkg::PEND_RESET;
        end
        else
        begin
            pending_q <= pend_d;
        end
    end

    // Masks start closed so nothing reaches the core until enabled.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mask_q <= cie_pkg::MASK_RESET;
        end
        else if (mask_wr)
        begin
            mask_q <= mask_wdata;
        end
    end

    // Gated requests feed the priority encoder.
    cie_enc_if enc_bus ();

    assign enc_bus.active = pending_q & mask_q;

    cie_prio_enc u_enc (
        .bus (enc_bus)
    );

    // Code and core request are registered together so they agree.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            int_code_q <= cie_pkg::CODE_DEFAULT;
            core_req_q <= 1'b0;
        end
        else
        begin
            int_code_q <= enc_bus.code;
            core_req_q <= enc_bus.any;
        end
    end

    // Flag views of the machine state.
    logic ee;
    logic vbase;

    assign ee    = machine_state_reg_q[cie_pkg::MSR_EXT_INT_ENABLE];
    assign vbase = machine_state_reg_q[cie_pkg::MSR_VECTOR_BASE_SELECT];

    // Both exceptions are only seen while the enable flag is set.
    logic ext_take;
    logic dec_take;
    logic any_take;

    assign ext_take = core_req_q & ee;
    assign dec_take = dec_req & ee;
    assign any_take = ext_take | dec_take;

    // Entry sequencer: hold issue, wait for the pipe to drain, switch.
    cie_pkg::cie_state_t state_q;
    cie_pkg::cie_state_t state_d;
    logic                drained;

    // A request that drops while draining simply releases the hold.
    assign drained = ~instr_busy;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            cie_pkg::CIE_IDLE:
            begin
                if (any_take)
                begin
                    state_d = cie_pkg::CIE_DRAIN;
                end
            end
            cie_pkg::CIE_DRAIN:
            begin
                if (!any_take)
                begin
                    state_d = cie_pkg::CIE_IDLE;
                end
                else if (drained)
                begin
                    state_d = cie_pkg::CIE_ENTER;
                end
            end
            cie_pkg::CIE_ENTER:
            begin
                state_d = cie_pkg::CIE_IDLE;
            end
            default:
            begin
                state_d = cie_pkg::CIE_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= cie_pkg::CIE_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Context is switched on the cycle the drain completes.
    logic switch_now;
    logic take_ext;

    assign switch_now = (state_q == cie_pkg::CIE_DRAIN) & any_take &
                        drained;
    // External interrupt wins over the decrementer when both arrive.
    assign take_ext   = ext_take;

    // Flags cleared on entry, collected into one mask.
    logic [31:0] entry_clear;

    assign entry_clear =
        (32'h1 << cie_pkg::MSR_RECOVERABLE) |
        (32'h1 << cie_pkg::MSR_USER_STATE) |
        (32'h1 << cie_pkg::MSR_BYTE_ORDER) |
        (32'h1 << cie_pkg::MSR_EXT_INT_ENABLE) |
        (32'h1 << cie_pkg::MSR_FLOAT_UNIT_ENABLE) |
        (32'h1 << cie_pkg::MSR_FLOAT_EXC_MODE_A) |
        (32'h1 << cie_pkg::MSR_FLOAT_EXC_MODE_B) |
        (32'h1 << cie_pkg::MSR_SINGLE_STEP_TRACE) |
        (32'h1 << cie_pkg::MSR_BRANCH_TRACE);

    // Vector target, offset placed on the high base when selected.
    logic [31:0] vec_off;
    logic [31:0] vec_pc;

    assign vec_off = take_ext ? cie_pkg::VEC_EXT_INT : cie_pkg::VEC_DECR;
    assign vec_pc  = vbase ? (cie_pkg::VEC_HIGH_BASE | vec_off)
                           : vec_off;

    // Saved state image: type info above, live state bits below.
    logic [31:0] saved_state_d;
    logic [15:0] exc_info;

    assign exc_info      = take_ext ? cie_pkg::EXC_INFO_EXT
                                    : cie_pkg::EXC_INFO_DEC;
    assign saved_state_d = {exc_info, 16'h0000} |
        (machine_state_reg_q & cie_pkg::MSR_LOW_HALF);

    // Flag port writes; the data word plays no part.
    logic spr_set_both;
    logic spr_dis_rec;
    logic spr_clr_both;

    assign spr_set_both = spr_wr &
        (spr_addr == cie_pkg::SPR_ENABLE_AND_RECOVER_SET);
    assign spr_dis_rec  = spr_wr &
        (spr_addr == cie_pkg::SPR_DISABLE_AND_RECOVER_SET);
    assign spr_clr_both = spr_wr &
        (spr_addr == cie_pkg::SPR_DISABLE_AND_UNRECOVER);

    // Next machine state; entry beats return, which beats software.
    logic [31:0] msr_d;

    always_comb
    begin
        msr_d = machine_state_reg_q;
        if (switch_now)
        begin
            msr_d = machine_state_reg_q & ~entry_clear;
        end
        else if (rfi_exec)
        begin
            msr_d = (machine_state_reg_q & ~cie_pkg::MSR_LOW_HALF) |
                    (saved_state_q & cie_pkg::MSR_LOW_HALF);
        end
        else if (msr_wr)
        begin
            msr_d = msr_wdata;
        end
        else if (spr_set_both)
        begin
            msr_d[cie_pkg::MSR_EXT_INT_ENABLE] = 1'b1;
            msr_d[cie_pkg::MSR_RECOVERABLE]    = 1'b1;
        end
        else if (spr_dis_rec)
        begin
            msr_d[cie_pkg::MSR_EXT_INT_ENABLE] = 1'b0;
            msr_d[cie_pkg::MSR_RECOVERABLE]    = 1'b1;
        end
        else if (spr_clr_both)
        begin
            msr_d[cie_pkg::MSR_EXT_INT_ENABLE] = 1'b0;
            msr_d[cie_pkg::MSR_RECOVERABLE]    = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            machine_state_reg_q <= cie_pkg::MSR_RESET_VAL;
        end
        else
        begin
            machine_state_reg_q <= msr_d;
        end
    end

    // Saved registers are overwritten on every entry.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            saved_pc_q    <= cie_pkg::SAVED_RESET;
            saved_state_q <= cie_pkg::SAVED_RESET;
        end
        else if (switch_now)
        begin
            saved_pc_q    <= next_pc;
            saved_state_q <= saved_state_d;
        end
    end

    // Fetch redirect is a one-cycle pulse with its target.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            redirect_q    <= 1'b0;
            redirect_pc_q <= cie_pkg::SAVED_RESET;
        end
        else if (switch_now)
        begin
            redirect_q    <= 1'b1;
            redirect_pc_q <= vec_pc;
        end
        else if (rfi_exec)
        begin
            redirect_q    <= 1'b1;
            redirect_pc_q <= saved_pc_q;
        end
        else
        begin
            redirect_q    <= 1'b0;
        end
    end

    // Issue stays held from the request until the redirect is out.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            issue_hold_q <= 1'b0;
        end
        else
        begin
            issue_hold_q <= (state_d == cie_pkg::CIE_DRAIN);
        end
    end

endmodule

/* File: logic/cie_enc_if.sv */
`timescale 1ns/1ps
// Carries the gated requests to the encoder and its result back.
interface cie_enc_if;
    logic [15:0] active;
    logic [7:0]  code;
    logic        any;

    modport ctrl (output active, input code, input any);
    modport enc  (input active, output code, output any);
endinterface

/* File: logic/cie_pkg.sv */
// What this block does
// - One interrupt request, honoured only while enabled.
// - Enable flag also gates the decrementer exception.
// - Drain executing instructions before the context switch.
// - Saved PC gets the next instruction address.
// - Saved state: state low half, type info high.
// - Entry clears nine listed machine state flags.
// - Interrupt vector 0x500 when base select is clear.
// - Ports 80/81/82 set or clear enable and recoverable.
// - Return reloads state bits 16 to 31.
// - Return reloads PC from the saved PC.
// - Controller takes eight active-low pins, eight levels.
// - System sources request on software-assigned levels.
// - Peripheral levels 7 to 31 merge onto level 7.
// - Sixteen inputs captured in a readable pending register.
// - Per-bit mask gates requests; masks clear at reset.
// - Lowest code wins; codes four apart, pins first.
// - Code defaults to 0x3C when nothing unmasked pends.
package cie_pkg;

    // Special register numbers of the three flag ports.
    localparam logic [9:0] SPR_ENABLE_AND_RECOVER_SET  = 10'h050;
    localparam logic [9:0] SPR_DISABLE_AND_RECOVER_SET = 10'h051;
    localparam logic [9:0] SPR_DISABLE_AND_UNRECOVER   = 10'h052;

    // Machine state bit positions, vector index = 31 - architected bit.
    localparam int MSR_EXT_INT_ENABLE     = 15;
    localparam int MSR_USER_STATE         = 14;
    localparam int MSR_FLOAT_UNIT_ENABLE  = 13;
    localparam int MSR_FLOAT_EXC_MODE_A   = 11;
    localparam int MSR_SINGLE_STEP_TRACE  = 10;
    localparam int MSR_BRANCH_TRACE       = 9;
    localparam int MSR_FLOAT_EXC_MODE_B   = 8;
    localparam int MSR_VECTOR_BASE_SELECT = 6;
    localparam int MSR_RECOVERABLE        = 1;
    localparam int MSR_BYTE_ORDER         = 0;

    // Architected bits 16..31 sit in the low half of the vector.
    localparam logic [31:0] MSR_LOW_HALF  = 32'h0000ffff;
    localparam logic [31:0] MSR_RESET_VAL = 32'h00000000;
    localparam logic [31:0] SAVED_RESET   = 32'h00000000;
    localparam logic [15:0] EXC_INFO_EXT  = 16'h0000;
    localparam logic [15:0] EXC_INFO_DEC  = 16'h0000;

    // Vector offsets and the high base used when base select is set.
    localparam logic [31:0] VEC_EXT_INT   = 32'h00000500;
    localparam logic [31:0] VEC_DECR      = 32'h00000900;
    localparam logic [31:0] VEC_HIGH_BASE = 32'hfff00000;

    // Controller geometry and codes.
    localparam int          NUM_PINS     = 8;
    localparam int          NUM_LEVELS   = 8;
    localparam int          NUM_INPUTS   = 16;
    localparam int          NUM_SYS_SRC  = 4;
    localparam int          NUM_PBUS_LVL = 32;
    localparam int          MERGE_LEVEL  = 7;
    localparam logic [7:0]  CODE_DEFAULT = 8'h3c;
    localparam int          CODE_SHIFT   = 2;

    localparam logic [15:0] MASK_RESET   = 16'h0000;
    localparam logic [15:0] PEND_RESET   = 16'h0000;

    // Entry sequencer states.
    typedef enum logic [2:0]
    {
        CIE_IDLE  = 3'b001,
        CIE_DRAIN = 3'b010,
        CIE_ENTER = 3'b100
    } cie_state_t;

endpackage

/* File: logic/cie_prio_enc.sv */
`timescale 1ns/1ps
// Picks the lowest numbered active input and reports its code.
module cie_prio_enc (
    cie_enc_if.enc bus
);
    // Scans from the top so the lowest index is the last to win.
    function automatic logic [7:0] pick_code(input logic [15:0] act);
        logic [7:0] c;
        c = cie_pkg::CODE_DEFAULT;
        for (int i = cie_pkg::NUM_INPUTS - 1; i >= 0; i--)
        begin
            if (act[i])
            begin
                c = 8'(i << cie_pkg::CODE_SHIFT);
            end
        end
        return c;
    endfunction

    assign bus.code = pick_code(bus.active);
    assign bus.any  = |bus.active;
endmodule

/* File: logic/cie_sync2.sv */
`timescale 1ns/1ps
// Two-stage synchroniser for a bus of independent level inputs.
module cie_sync2 #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // Idle pins are high, so both stages reset to all ones.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_q   <= '1;
            sync_out <= '1;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

/* File: tb/cie_core_int_props.sv */
`timescale 1ns/1ps
// Port-level checks for the interrupt entry block and its controller.
module cie_core_int_props (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [7:0]  irq_pin_n,
    input wire logic [3:0]  sys_src_req,
    input wire logic [31:0] sys_src_level,
    input wire logic [31:0] pbus_level_req,
    input wire logic        mask_wr,
    input wire logic [15:0] mask_wdata,
    input wire logic        spr_wr,
    input wire logic [9:0]  spr_addr,
    input wire logic [31:0] spr_wdata,
    input wire logic        msr_wr,
    input wire logic [31:0] msr_wdata,
    input wire logic        dec_req,
    input wire logic        instr_busy,
    input wire logic [31:0] next_pc,
    input wire logic        rfi_exec,
    input wire logic [15:0] pending_q,
    input wire logic [15:0] mask_q,
    input wire logic [7:0]  int_code_q,
    input wire logic        core_req_q,
    input wire logic [31:0] machine_state_reg_q,
    input wire logic [31:0] saved_pc_q,
    input wire logic [31:0] saved_state_q,
    input wire logic        issue_hold_q,
    input wire logic        redirect_q,
    input wire logic [31:0] redirect_pc_q
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // Unmasked requests and the pin half of the pending bits.
    wire logic [15:0] live = pending_q & mask_q;
    wire logic [7:0]  pin_pend = {pending_q[14], pending_q[12],
        pending_q[10], pending_q[8], pending_q[6], pending_q[4],
        pending_q[2], pending_q[0]};

    a_code_idle:
        assert property (live == 16'h0000 |=> int_code_q == 8'h3c)
        else $error("Idle code wrong.");
    a_code_lowest:
        assert property (live != 16'h0000 |=> int_code_q[1:0] == 2'b00
            && int_code_q < 8'h40
            && ($past(live) >> int_code_q[5:2]) % 2 == 1
            && ($past(live) << (16 - int_code_q[5:2])) == 16'h0000)
        else $error("Priority code wrong.");
    a_req_follows:
        assert property (core_req_q == ($past(live) != 16'h0000))
        else $error("Core request wrong.");
    a_mask_load:
        assert property (mask_wr |=> mask_q == $past(mask_wdata))
        else $error("Mask not loaded.");
    a_level_merge:
        assert property (|pbus_level_req[31:7] |=> pending_q[15])
        else $error("Level merge missing.");
    a_pin_pending:
        assert property ($stable(irq_pin_n) [*3]
            |=> pin_pend == ~$past(irq_pin_n))
        else $error("Pin pending wrong.");
    a_flag_ports:
        assert property (spr_wr && !msr_wr && !rfi_exec
            && spr_addr inside {10'h050, 10'h051, 10'h052}
            |=> redirect_q || {machine_state_reg_q[15],
            machine_state_reg_q[1]} == ($past(spr_addr) == 10'h050
            ? 2'b11 : $past(spr_addr) == 10'h051 ? 2'b01 : 2'b00))
        else $error("Flag port write wrong.");
    a_return_restore:
        assert property (rfi_exec && !issue_hold_q |=> redirect_q
            && redirect_pc_q == $past(saved_pc_q)
            && machine_state_reg_q[15:0] == $past(saved_state_q[15:0]))
        else $error("Return restore wrong.");
    a_enable_gate:
        assert property ($rose(issue_hold_q)
            |-> $past(machine_state_reg_q[15] && (core_req_q || dec_req)))
        else $error("Entry without enable.");
    a_drain_first:
        assert property ($fell(issue_hold_q) && redirect_q
            && !$past(rfi_exec) |-> !$past(instr_busy))
        else $error("Entry before drain.");
    a_entry_context:
        assert property ($fell(issue_hold_q) && redirect_q
            && !$past(rfi_exec) |-> saved_pc_q == $past(next_pc)
            && saved_state_q == {16'h0000, $past(machine_state_reg_q[15:0])}
            && (machine_state_reg_q & 32'h0000ef03) == 32'h00000000
            && redirect_pc_q == (($past(machine_state_reg_q[6])
            ? cie_pkg::VEC_HIGH_BASE : 32'h00000000) | ($past(core_req_q)
            ? cie_pkg::VEC_EXT_INT : cie_pkg::VEC_DECR)))
        else $error("Entry context wrong.");
endmodule

bind cie_core_int cie_core_int_props cie_core_int_props_i (.clk, .nrst,
    .irq_pin_n, .sys_src_req, .sys_src_level, .pbus_level_req, .mask_wr,
    .mask_wdata, .spr_wr, .spr_addr, .spr_wdata, .msr_wr, .msr_wdata,
    .dec_req, .instr_busy, .next_pc, .rfi_exec, .pending_q, .mask_q,
    .int_code_q, .core_req_q, .machine_state_reg_q, .saved_pc_q,
    .saved_state_q, .issue_hold_q, .redirect_q, .redirect_pc_q);

/* File: tb/cie_pin_model.sv */
`timescale 1ns/1ps
// Stands in for the external request pins; a quiet pin sits high.
module cie_pin_model (
    input  wire logic       clk,
    input  wire logic [7:0] pins_on,
    output logic      [7:0] irq_pin_n
);
    initial irq_pin_n = 8'hff;

    // Pins move just after the edge, never on it, so sampling is clean.
    always @(posedge clk)
        irq_pin_n <= #1 ~pins_on;
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
// Self-checking bench for the interrupt entry block and its controller.
module testbench;
    logic        clk = 1'b0;
    logic        nrst, mask_wr, spr_wr, msr_wr, dec_req, instr_busy;
    logic        rfi_exec, core_req_q, issue_hold_q, redirect_q;
    logic [7:0]  pins_on, irq_pin_n, int_code_q;
    logic [3:0]  sys_src_req;
    logic [9:0]  spr_addr;
    logic [15:0] mask_wdata, pending_q, mask_q, msk, exp;
    logic [31:0] sys_src_level, pbus_level_req, spr_wdata, msr_wdata;
    logic [31:0] next_pc, machine_state_reg_q, saved_pc_q, saved_state_q;
    logic [31:0] redirect_pc_q, pc, st;
    integer      seed, failures, num_checks;
    logic [9:0]  adr [4] = '{10'h050, 10'h053, 10'h051, 10'h052};
    logic [1:0]  flg [4] = '{2'b11, 2'b11, 2'b01, 2'b00};
    wire logic [1:0] ee_ri = {machine_state_reg_q[15], machine_state_reg_q[1]};

    cie_pin_model cie_pin_model_i (.clk, .pins_on, .irq_pin_n);
    cie_core_int cie_core_int_i (.clk, .nrst, .irq_pin_n, .sys_src_req,
        .sys_src_level, .pbus_level_req, .mask_wr, .mask_wdata, .spr_wr,
        .spr_addr, .spr_wdata, .msr_wr, .msr_wdata, .dec_req, .instr_busy,
        .next_pc, .rfi_exec, .pending_q, .mask_q, .int_code_q, .core_req_q,
        .machine_state_reg_q, .saved_pc_q, .saved_state_q, .issue_hold_q,
        .redirect_q, .redirect_pc_q);

    // Free-running system clock.
    always #5 clk = ~clk;

    // Inputs always change one nanosecond after the rising edge.
    task automatic tick(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] want);
        num_checks++;
        if (got !== want)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got %h want %h", $time, got, want);
        end
    endtask

    task automatic conclude;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Bounded wait for the hold flag (sel high) or the redirect pulse.
    task automatic wait_for(input logic sel);
        integer n;
        n = 0;
        while ((sel ? issue_hold_q : redirect_q) !== 1'b1)
        begin
            n++;
            if (n > 30)
            begin
                failures++;
                $display("CHECK FAILED t=%0t wait timed out", $time);
                conclude();
            end
            tick(1);
        end
    endtask

    // Single-cycle strobes; callers let an edge pass before the next one.
    task automatic put_mask(input logic [15:0] m);
        mask_wdata = m;
        mask_wr = 1'b1;
        tick(1);
        mask_wr = 1'b0;
    endtask

    task automatic put_msr(input logic [31:0] v);
        msr_wdata = v;
        msr_wr = 1'b1;
        tick(1);
        msr_wr = 1'b0;
    endtask

    task automatic spr(input logic [9:0] a);
        spr_addr = a;
        spr_wdata = $random(seed);
        spr_wr = 1'b1;
        tick(1);
        spr_wr = 1'b0;
    endtask

    // Pin k lands at bit 2k, level k at 2k+1; peripheral 7..31 on level 7.
    function automatic logic [15:0] exp_pend(input logic [7:0] p,
        input logic [3:0] s, input logic [31:0] lv, input logic [31:0] pb);
        logic [15:0] r;
        r = 16'h0000;
        for (int k = 0; k < 8; k++)
        begin
            r[2*k] = p[k];
            r[2*k+1] = (k == 7) ? |pb[31:7] : pb[k];
            for (int j = 0; j < 4; j++)
                r[2*k+1] |= s[j] & lv[8*j+7-k];
        end
        return r;
    endfunction

    // Lowest set index wins, four apart; nothing pending gives 0x3c.
    function automatic logic [7:0] exp_code(input logic [15:0] a);
        logic [7:0] r;
        r = 8'h3c;
        for (int k = 15; k >= 0; k--)
            if (a[k])
                r = 8'(4 * k);
        return r;
    endfunction

    // Main sequence: reset, random priority mix, flag ports, entry, return.
    initial
    begin
        {seed, failures, num_checks} = {32'sh1f, 32'sh0, 32'sh0};
        {pins_on, sys_src_req, sys_src_level, pbus_level_req} = '0;
        {mask_wr, mask_wdata, spr_wr, spr_addr, spr_wdata, msr_wr} = '0;
        {msr_wdata, dec_req, instr_busy, next_pc, rfi_exec} = '0;
        nrst = 1'b0;
        tick(12);
        nrst = 1'b1;
        tick(1);
        check(mask_q, 32'h00000000);
        check(int_code_q, 32'h0000003c);
        $display("reset test done");
        for (int n = 0; n < 40; n++)
        begin
            pins_on = $random(seed) & $random(seed) & $random(seed);
            sys_src_req = $random(seed);
            for (int j = 0; j < 4; j++)
                sys_src_level[8*j +: 8] = 8'h80 >> ($random(seed) & 7);
            pbus_level_req = $random(seed) & $random(seed) & $random(seed);
            msk = $random(seed);
            if (n < 2)
            begin
                {sys_src_req, pbus_level_req, msk} = {36'h0, 16'hffff};
                pins_on = {8{n[0]}};
            end
            put_mask(msk);
            check(mask_q, msk);
            tick(6);
            exp = exp_pend(pins_on, sys_src_req, sys_src_level,
                pbus_level_req);
            check(pending_q, exp);
            check(int_code_q, exp_code(exp & msk));
            check(core_req_q, |(exp & msk));
            check(issue_hold_q, 1'b0);
        end
        {pins_on, sys_src_req, pbus_level_req} = '0;
        put_mask(16'h0000);
        tick(6);
        $display("priority test done");
        spr_wr = 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            spr_addr = adr[k];
            spr_wdata = $random(seed);
            tick(1);
            check(ee_ri, flg[k]);
        end
        spr_wr = 1'b0;
        $display("flag port test done");
        st = {16'h0000, (16'($random(seed)) & 16'hffbf) | 16'h8000};
        instr_busy = 1'b1;
        put_msr(st);
        put_mask(16'h0010);
        pins_on = 8'h04;
        wait_for(1'b1);
        tick(3);
        check(redirect_q, 1'b0);
        pc = $random(seed) & 32'hfffffffc;
        next_pc = pc;
        instr_busy = 1'b0;
        wait_for(1'b0);
        check(saved_pc_q, pc);
        check(saved_state_q, {16'h0000, st[15:0]});
        check(machine_state_reg_q, st & ~32'h0000ef03);
        check(redirect_pc_q, 32'h00000500);
        pins_on = 8'h00;
        tick(12);
        spr(10'h051);
        check(ee_ri, 2'b01);
        rfi_exec = 1'b1;
        tick(1);
        rfi_exec = 1'b0;
        check(redirect_pc_q, pc);
        check(machine_state_reg_q, st);
        $display("entry and return test done");
        put_msr(32'h00000040);
        dec_req = 1'b1;
        tick(5);
        check(issue_hold_q, 1'b0);
        spr(10'h050);
        wait_for(1'b0);
        check(redirect_pc_q, 32'hfff00900);
        dec_req = 1'b0;
        $display("decrementer test done");
        // A reset in mid-run must close the masks and drop every request.
        put_mask(16'hffff);
        nrst = 1'b0;
        tick(2);
        nrst = 1'b1;
        tick(1);
        check(mask_q, 32'h00000000);
        check(int_code_q, 32'h0000003c);
        check(core_req_q, 1'b0);
        check(machine_state_reg_q, 32'h00000000);
        $display("mid-run reset test done");
        conclude();
    end
endmodule
